// ==== include/vsl_defines.vh ====
// register offsets, field positions and reset values for the sync and luminance control bank
`ifndef VSL_DEFINES_VH
`define VSL_DEFINES_VH

`define SUB_SYNC_CONTROL 8'h08
`define SUB_LUMA_CONTROL 8'h09
`define SUB_BRIGHTNESS 8'h0a

`define SYNC_AUTO_FIELD_BIT 7
`define SYNC_MANUAL_RATE_BIT 6
`define SYNC_FORCED_TOGGLE_BIT 5
`define SYNC_HTC_MSB 4
`define SYNC_HTC_LSB 3
`define SYNC_HLOOP_OPEN_BIT 2
`define SYNC_VNOISE_MSB 1
`define SYNC_VNOISE_LSB 0

`define LUMA_BYPASS_BIT 7
`define LUMA_COMB_BIT 6
`define LUMA_DELAY_BIT 5
`define LUMA_NOTCH_BIT 4
`define LUMA_SHARP_MSB 3
`define LUMA_SHARP_LSB 0

`define HTC_TV 2'h0
`define HTC_VTR 2'h1
`define HTC_RESERVED 2'h2
`define HTC_FAST 2'h3

`define VNOISE_NORMAL 2'h0
`define VNOISE_FAST 2'h1
`define VNOISE_FREE 2'h2
`define VNOISE_BYPASS 2'h3

`define RST_SYNC_CONTROL 8'h98
`define RST_LUMA_CONTROL 8'h00
`define RST_BRIGHTNESS 8'h80

`define DELAY_LINES_NTSC 2'h1
`define DELAY_LINES_PAL 2'h2

`endif

// ==== rtl/sync2.v ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  input wire clock,
  input wire rst_b,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] stage1_reg;

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1_reg <= RESET_VAL;
      q <= RESET_VAL;
    end
    else
    begin
      stage1_reg <= d;
      q <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/luma_decode.v ====
// registered decode of the luminance control byte into datapath selects
`timescale 1ns/1ns
`default_nettype none
`include "vsl_defines.vh"
module luma_decode (
  input wire clock,
  input wire rst_b,
  input wire [7:0] luma_ctrl,
  input wire pal_standard,
  output reg filter_bypass,
  output reg comb_active,
  output reg trap_active,
  output reg [1:0] extra_delay_lines,
  output reg notch_wide,
  output reg peaking_enable,
  output reg [2:0] peaking_step,
  output reg lowpass_enable,
  output reg [2:0] lowpass_step,
  output reg lowpass_notch
);
  wire bypass_w = luma_ctrl[`LUMA_BYPASS_BIT];
  wire comb_w = luma_ctrl[`LUMA_COMB_BIT];
  wire [3:0] sharp_w = luma_ctrl[`LUMA_SHARP_MSB:`LUMA_SHARP_LSB];

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      filter_bypass <= 1'b0;
      comb_active <= 1'b0;
      trap_active <= 1'b1;
      extra_delay_lines <= 2'h0;
      notch_wide <= 1'b0;
      peaking_enable <= 1'b0;
      peaking_step <= 3'h0;
      lowpass_enable <= 1'b0;
      lowpass_step <= 3'h0;
      lowpass_notch <= 1'b0;
    end
    else
    begin
      filter_bypass <= bypass_w;
      comb_active <= ~bypass_w & comb_w;
      trap_active <= ~bypass_w & ~comb_w;
      // extra delay only matters while the comb is not the active filter
      if (luma_ctrl[`LUMA_DELAY_BIT] && !(~bypass_w & comb_w))
        extra_delay_lines <= pal_standard ? `DELAY_LINES_PAL : `DELAY_LINES_NTSC;
      else
        extra_delay_lines <= 2'h0;
      notch_wide <= luma_ctrl[`LUMA_NOTCH_BIT];
      // step 1 is the strongest peaking, 7 the weakest
      peaking_enable <= ~sharp_w[3] & (sharp_w[2:0] != 3'h0);
      peaking_step <= sharp_w[3] ? 3'h0 : sharp_w[2:0];
      // step 0 is the widest low-pass, 7 the narrowest
      lowpass_enable <= sharp_w[3];
      lowpass_step <= sharp_w[3] ? sharp_w[2:0] : 3'h0;
      lowpass_notch <= sharp_w[3] & (sharp_w[2:0] >= 3'h5);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/video_sync_luma_control.v ====
// sync and luminance control register bank behind a two-wire control bus slave
// Contract
// - auto field detect set: field rate follows detector; clear: follows manual bit.
// - manual rate bit: 0 gives 50 Hz/625 lines, 1 gives 60 Hz/525 lines.
// - parity toggles on interlaced fields only, or every field when forced toggle set.
// - horizontal time constant: 00 TV, 01 VTR, 11 fast lock, 10 reserved.
// - horizontal loop bit: 0 loop closed, 1 loop open with fixed frequency.
// - vertical noise field: 00 normal, 01 fast, 10 free running, 11 bypass.
// - bypass bit 0 keeps trap or comb active; 1 bypasses both.
// - with bypass clear, comb bit 1 enables adaptive comb, 0 chroma trap.
// - delay bit adds one NTSC or two PAL lines in non-comb mode.
// - notch bit: 0 narrow notch wide luma, 1 wide notch narrow luma.
// - sharpness 0000 plain; 0001 to 0111 peaking, decreasing strength.
// - sharpness 1000 to 1111 narrower low-pass; 1101 to 1111 add a notch.
// - brightness byte sets luma offset: 0 dark, 128 nominal, 255 bright.
`timescale 1ns/1ns
`default_nettype none
`include "vsl_defines.vh"
module video_sync_luma_control #(
  // bus address of this device; value is arbitrary
  parameter [6:0] DEVICE_ADDR = 7'h2a
) (
  input wire CLOCK,
  input wire RST_B,
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  input wire DETECTED_60HZ,
  input wire FIELD_START,
  input wire SOURCE_INTERLACED,
  input wire PAL_STANDARD,
  output reg AUTO_FIELD_DETECT,
  output reg FIELD_RATE_60,
  output reg ODD_EVEN,
  output reg [1:0] HORIZ_TIME_CONSTANT,
  output reg HTC_MODE_TV,
  output reg HTC_MODE_VTR,
  output reg HTC_MODE_FAST,
  output reg HORIZ_LOOP_OPEN,
  output reg VNOISE_NORMAL,
  output reg VNOISE_FAST,
  output reg VNOISE_FREE_RUN,
  output reg VNOISE_BYPASS,
  output wire FILTER_BYPASS,
  output wire COMB_ACTIVE,
  output wire TRAP_ACTIVE,
  output wire [1:0] EXTRA_DELAY_LINES,
  output wire NOTCH_WIDE,
  output wire PEAKING_ENABLE,
  output wire [2:0] PEAKING_STEP,
  output wire LOWPASS_ENABLE,
  output wire [2:0] LOWPASS_STEP,
  output wire LOWPASS_NOTCH,
  output reg [7:0] BRIGHTNESS_OFFSET_VALUE
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_SUB = 3'h2;
  localparam [2:0] ST_WRITE = 3'h3;
  localparam [2:0] ST_READ = 3'h4;

  reg [7:0] sync_control_reg;
  reg [7:0] luminance_control_reg;
  reg [7:0] brightness_offset_reg;

  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] pointer_reg;
  reg in_ack_reg;
  reg master_ack_reg;
  reg scl_d_reg;
  reg sda_d_reg;
  wire [1:0] pins_sync;
  wire scl_s = pins_sync[1];
  wire sda_s = pins_sync[0];

  // bus pins come from outside the clock domain
  sync2 #(
    .WIDTH(2),
    .RESET_VAL(2'h3)
  ) pin_sync (
    .clock(CLOCK),
    .rst_b(RST_B),
    .d({SCL_IN, SDA_IN}),
    .q(pins_sync)
  );

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  reg [7:0] read_data;
  reg [7:0] next_read_data;
  always @*
  begin
    case (pointer_reg)
      `SUB_SYNC_CONTROL: read_data = sync_control_reg;
      `SUB_LUMA_CONTROL: read_data = luminance_control_reg;
      `SUB_BRIGHTNESS: read_data = brightness_offset_reg;
      default: read_data = 8'h00;
    endcase
  end

  always @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // bus slave: sample on scl rising, drive on scl falling, so data is stable while scl is high
  always @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      pointer_reg <= 8'h00;
      in_ack_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      sync_control_reg <= `RST_SYNC_CONTROL;
      luminance_control_reg <= `RST_LUMA_CONTROL;
      brightness_offset_reg <= `RST_BRIGHTNESS;
    end
    else if (bus_start)
    begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      in_ack_reg <= 1'b0;
      SDA_OE <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_reg <= ST_IDLE;
      in_ack_reg <= 1'b0;
      SDA_OE <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_ADDR, ST_SUB, ST_WRITE:
        begin
          if (scl_rise && !in_ack_reg && bit_cnt_reg != 4'h8)
          begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && in_ack_reg)
          begin
            in_ack_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            SDA_OE <= 1'b0;
            if (state_reg == ST_ADDR && shift_reg[0])
            begin
              // read begins at the current subaddress
              state_reg <= ST_READ;
              shift_reg <= read_data;
              SDA_OE <= ~read_data[7];
            end
            else if (state_reg == ST_ADDR)
              state_reg <= ST_SUB;
            else
              state_reg <= ST_WRITE;
          end
          else if (scl_fall && bit_cnt_reg == 4'h8)
          begin
            if (state_reg == ST_ADDR && shift_reg[7:1] != DEVICE_ADDR)
              state_reg <= ST_IDLE;
            else
            begin
              in_ack_reg <= 1'b1;
              SDA_OE <= 1'b1;
              if (state_reg == ST_SUB)
                pointer_reg <= shift_reg;
              if (state_reg == ST_WRITE)
              begin
                // writes to other subaddresses are acknowledged and dropped
                case (pointer_reg)
                  `SUB_SYNC_CONTROL: sync_control_reg <= shift_reg;
                  `SUB_LUMA_CONTROL: luminance_control_reg <= shift_reg;
                  `SUB_BRIGHTNESS: brightness_offset_reg <= shift_reg;
                  default: pointer_reg <= pointer_reg;
                endcase
                pointer_reg <= pointer_reg + 8'h01;
              end
            end
          end
        end
        ST_READ:
        begin
          if (scl_rise && bit_cnt_reg != 4'h8)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          else if (scl_rise)
            master_ack_reg <= ~sda_s;
          else if (scl_fall && bit_cnt_reg == 4'h8 && !in_ack_reg)
          begin
            // release the line for the master's acknowledge
            SDA_OE <= 1'b0;
            in_ack_reg <= 1'b1;
          end
          else if (scl_fall && bit_cnt_reg == 4'h8)
          begin
            in_ack_reg <= 1'b0;
            if (master_ack_reg)
            begin
              pointer_reg <= pointer_reg + 8'h01;
              bit_cnt_reg <= 4'h0;
              shift_reg <= next_read_data;
              SDA_OE <= ~next_read_data[7];
            end
            else
              state_reg <= ST_IDLE;
          end
          else if (scl_fall && bit_cnt_reg != 4'h8)
            SDA_OE <= ~shift_reg[3'h7 - bit_cnt_reg[2:0]];
        end
        default:
        begin
          SDA_OE <= 1'b0;
          in_ack_reg <= 1'b0;
        end
      endcase
    end
  end

  always @*
  begin
    case (pointer_reg + 8'h01)
      `SUB_SYNC_CONTROL: next_read_data = sync_control_reg;
      `SUB_LUMA_CONTROL: next_read_data = luminance_control_reg;
      `SUB_BRIGHTNESS: next_read_data = brightness_offset_reg;
      default: next_read_data = 8'h00;
    endcase
  end

  wire auto_field_detect = sync_control_reg[`SYNC_AUTO_FIELD_BIT];
  wire manual_field_rate = sync_control_reg[`SYNC_MANUAL_RATE_BIT];
  wire forced_parity_toggle = sync_control_reg[`SYNC_FORCED_TOGGLE_BIT];
  wire [1:0] horiz_time_constant = sync_control_reg[`SYNC_HTC_MSB:`SYNC_HTC_LSB];
  wire [1:0] vert_noise_mode = sync_control_reg[`SYNC_VNOISE_MSB:`SYNC_VNOISE_LSB];

  // settings take effect one clock after the write, no restart needed
  always @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      AUTO_FIELD_DETECT <= 1'b1;
      FIELD_RATE_60 <= 1'b0;
      ODD_EVEN <= 1'b0;
      HORIZ_TIME_CONSTANT <= `HTC_FAST;
      HTC_MODE_TV <= 1'b0;
      HTC_MODE_VTR <= 1'b0;
      HTC_MODE_FAST <= 1'b1;
      HORIZ_LOOP_OPEN <= 1'b0;
      VNOISE_NORMAL <= 1'b1;
      VNOISE_FAST <= 1'b0;
      VNOISE_FREE_RUN <= 1'b0;
      VNOISE_BYPASS <= 1'b0;
      BRIGHTNESS_OFFSET_VALUE <= `RST_BRIGHTNESS;
    end
    else
    begin
      AUTO_FIELD_DETECT <= auto_field_detect;
      FIELD_RATE_60 <= auto_field_detect ? DETECTED_60HZ : manual_field_rate;
      // a progressive source gets no parity changes unless forced
      if (FIELD_START && (SOURCE_INTERLACED || forced_parity_toggle))
        ODD_EVEN <= ~ODD_EVEN;
      HORIZ_TIME_CONSTANT <= horiz_time_constant;
      // the reserved code selects no mode at all
      HTC_MODE_TV <= horiz_time_constant == `HTC_TV;
      HTC_MODE_VTR <= horiz_time_constant == `HTC_VTR;
      HTC_MODE_FAST <= horiz_time_constant == `HTC_FAST;
      HORIZ_LOOP_OPEN <= sync_control_reg[`SYNC_HLOOP_OPEN_BIT];
      VNOISE_NORMAL <= vert_noise_mode == `VNOISE_NORMAL;
      // fast mode is not blocked when auto detect is on; that pairing is the host's duty
      VNOISE_FAST <= vert_noise_mode == `VNOISE_FAST;
      VNOISE_FREE_RUN <= vert_noise_mode == `VNOISE_FREE;
      VNOISE_BYPASS <= vert_noise_mode == `VNOISE_BYPASS;
      BRIGHTNESS_OFFSET_VALUE <= brightness_offset_reg;
    end
  end

  luma_decode luma_dec (
    .clock(CLOCK),
    .rst_b(RST_B),
    .luma_ctrl(luminance_control_reg),
    .pal_standard(PAL_STANDARD),
    .filter_bypass(FILTER_BYPASS),
    .comb_active(COMB_ACTIVE),
    .trap_active(TRAP_ACTIVE),
    .extra_delay_lines(EXTRA_DELAY_LINES),
    .notch_wide(NOTCH_WIDE),
    .peaking_enable(PEAKING_ENABLE),
    .peaking_step(PEAKING_STEP),
    .lowpass_enable(LOWPASS_ENABLE),
    .lowpass_step(LOWPASS_STEP),
    .lowpass_notch(LOWPASS_NOTCH)
  );
endmodule
`default_nettype wire

// ==== tb/vsl_monitor.sv ====
// concurrent checks on the ports of the sync and luminance control bank
`timescale 1ns/1ns
`default_nettype none
module vsl_monitor (
  input wire CLOCK,
  input wire RST_B,
  input wire SDA_OUT,
  input wire DETECTED_60HZ,
  input wire FIELD_START,
  input wire SOURCE_INTERLACED,
  input wire PAL_STANDARD,
  input wire AUTO_FIELD_DETECT,
  input wire FIELD_RATE_60,
  input wire ODD_EVEN,
  input wire [1:0] HORIZ_TIME_CONSTANT,
  input wire HTC_MODE_TV,
  input wire HTC_MODE_VTR,
  input wire HTC_MODE_FAST,
  input wire VNOISE_NORMAL,
  input wire VNOISE_FAST,
  input wire VNOISE_FREE_RUN,
  input wire VNOISE_BYPASS,
  input wire FILTER_BYPASS,
  input wire COMB_ACTIVE,
  input wire TRAP_ACTIVE,
  input wire [1:0] EXTRA_DELAY_LINES,
  input wire PEAKING_ENABLE,
  input wire LOWPASS_ENABLE,
  input wire [2:0] LOWPASS_STEP,
  input wire LOWPASS_NOTCH
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // a field pulse that must flip parity, and a cycle with no field pulse
  sequence field_taken;
    FIELD_START && SOURCE_INTERLACED;
  endsequence
  sequence field_idle;
    !FIELD_START;
  endsequence
  a_rate_follows_detect:
    assert property ($past(RST_B) && AUTO_FIELD_DETECT |-> FIELD_RATE_60 == $past(DETECTED_60HZ))
    else $error("field rate not following detector");
  a_parity_toggles:
    assert property (field_taken |=> ODD_EVEN != $past(ODD_EVEN)) else $error("parity did not toggle");
  a_parity_holds:
    assert property (field_idle |=> $stable(ODD_EVEN)) else $error("parity moved without field");
  a_htc_decode:
    assert property ({HTC_MODE_FAST, HTC_MODE_VTR, HTC_MODE_TV} == {HORIZ_TIME_CONSTANT == 2'h3,
      HORIZ_TIME_CONSTANT == 2'h1, HORIZ_TIME_CONSTANT == 2'h0}) else $error("time constant decode");
  a_vnoise_onehot:
    assert property ($onehot({VNOISE_BYPASS, VNOISE_FREE_RUN, VNOISE_FAST, VNOISE_NORMAL}))
    else $error("noise mode not one-hot");
  a_filter_path:
    assert property (!(COMB_ACTIVE && TRAP_ACTIVE) && FILTER_BYPASS == !(COMB_ACTIVE || TRAP_ACTIVE))
    else $error("filter path selects");
  a_delay_lines:
    assert property (EXTRA_DELAY_LINES != 2'h0 |-> !COMB_ACTIVE
      && EXTRA_DELAY_LINES == ($past(PAL_STANDARD) ? 2'h2 : 2'h1)) else $error("extra delay lines");
  a_lowpass_notch:
    assert property (LOWPASS_NOTCH |-> LOWPASS_ENABLE && LOWPASS_STEP >= 3'h5 && !PEAKING_ENABLE)
    else $error("low-pass notch decode");
  a_open_drain:
    assert property (SDA_OUT == 1'b0) else $error("data pin driven high");
endmodule
bind video_sync_luma_control vsl_monitor mon (.*);
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the sync and luminance control bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  localparam [6:0] DEV = 7'h2a;
  logic CLOCK = 0, RST_B = 0, SCL_IN = 1, sda_m = 1;
  logic DETECTED_60HZ = 0, FIELD_START = 0, SOURCE_INTERLACED = 0, PAL_STANDARD = 0;
  wire SDA_OUT, SDA_OE, AUTO_FIELD_DETECT, FIELD_RATE_60, ODD_EVEN, HTC_MODE_TV, HTC_MODE_VTR, HTC_MODE_FAST;
  wire HORIZ_LOOP_OPEN, VNOISE_NORMAL, VNOISE_FAST, VNOISE_FREE_RUN, VNOISE_BYPASS, FILTER_BYPASS, COMB_ACTIVE;
  wire TRAP_ACTIVE, NOTCH_WIDE, PEAKING_ENABLE, LOWPASS_ENABLE, LOWPASS_NOTCH;
  wire [1:0] HORIZ_TIME_CONSTANT, EXTRA_DELAY_LINES;
  wire [2:0] PEAKING_STEP, LOWPASS_STEP;
  wire [7:0] BRIGHTNESS_OFFSET_VALUE;
  // open-drain wire: the host releases high, the device can only pull low
  wire SDA_IN = sda_m & ~SDA_OE;
  integer fails = 0, cmp_count = 0, seed = 32'h3f7d, i;
  logic [7:0] q, d;
  logic a;
  video_sync_luma_control #(.DEVICE_ADDR(DEV)) dut (.*);
  initial forever #10 CLOCK = ~CLOCK;
  task tick(input integer n);
    repeat (n) @(posedge CLOCK);
  endtask
  // five cycles per phase keeps well above the four-cycle minimum
  task bitx(input logic b, output logic r);
    sda_m <= b;
    tick(5);
    SCL_IN <= 1'b1;
    tick(5);
    r = SDA_IN;
    SCL_IN <= 1'b0;
    tick(5);
  endtask
  task bytex(input [7:0] b, input logic m, output [7:0] r, output logic k);
    for (int j = 7; j >= 0; j--) bitx(b[j], r[j]);
    bitx(m, k);
  endtask
  task start;
    sda_m <= 1'b1;
    tick(5);
    SCL_IN <= 1'b1;
    tick(5);
    sda_m <= 1'b0;
    tick(5);
    SCL_IN <= 1'b0;
    tick(5);
  endtask
  task stop;
    sda_m <= 1'b0;
    tick(5);
    SCL_IN <= 1'b1;
    tick(5);
    sda_m <= 1'b1;
    tick(5);
  endtask
  task wr(input [7:0] s, input [7:0] v);
    start;
    bytex({DEV, 1'b0}, 1'b1, q, a);
    bytex(s, 1'b1, q, a);
    bytex(v, 1'b1, q, a);
    `CHK("write ack", 1'b0, a)
    stop;
  endtask
  task rd(input [7:0] s, input [7:0] e);
    start;
    bytex({DEV, 1'b0}, 1'b1, q, a);
    bytex(s, 1'b1, q, a);
    start;
    bytex({DEV, 1'b1}, 1'b1, q, a);
    bytex(8'hff, 1'b1, q, a);
    stop;
    `CHK("readback", e, q)
  endtask
  function [8:0] luma_exp(input [7:0] v, input logic pal);
    logic comb;
    comb = !v[7] && v[6];
    luma_exp = {v[7], comb, !v[7] && !v[6], (v[5] && !comb) ? (pal ? 2'h2 : 2'h1) : 2'h0, v[4],
      v[3:0] != 4'h0 && !v[3], v[3], v[3:0] >= 4'hd};
  endfunction
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    tick(90000);
    fails++;
    finish_test;
  end
  initial
  begin
    tick(8);
    RST_B <= 1'b1;
    tick(4);
    `CHK("reset outs", 5'h1f, {AUTO_FIELD_DETECT, HORIZ_TIME_CONSTANT, VNOISE_NORMAL, TRAP_ACTIVE})
    rd(8'h08, 8'h98);
    rd(8'h09, 8'h00);
    rd(8'h0a, 8'h80);
    $display("test reset done");
    for (i = 0; i < 16; i++)
    begin
      d = $random(seed);
      d[4:3] = i[3:2];
      d[1:0] = i[1:0];
      d[7] = d[7] && (i[1:0] != 2'h1);
      DETECTED_60HZ <= $random(seed);
      wr(8'h08, d);
      tick(3);
      `CHK("auto detect", d[7], AUTO_FIELD_DETECT)
      `CHK("field rate", d[7] ? DETECTED_60HZ : d[6], FIELD_RATE_60)
      `CHK("htc", {d[4:3], d[4:3] == 2'h3, d[4:3] == 2'h1, d[4:3] == 2'h0},
        {HORIZ_TIME_CONSTANT, HTC_MODE_FAST, HTC_MODE_VTR, HTC_MODE_TV})
      `CHK("loop open", d[2], HORIZ_LOOP_OPEN)
      `CHK("vnoise", 4'h1 << d[1:0], {VNOISE_BYPASS, VNOISE_FREE_RUN, VNOISE_FAST, VNOISE_NORMAL})
      rd(8'h08, d);
    end
    $display("test sync done");
    for (i = 0; i < 16; i++)
    begin
      d = {i[2:0], 1'b0, i[3:0]};
      d[4] = $random(seed);
      PAL_STANDARD <= $random(seed);
      wr(8'h09, d);
      tick(3);
      `CHK("luma", luma_exp(d, PAL_STANDARD), {FILTER_BYPASS, COMB_ACTIVE, TRAP_ACTIVE, EXTRA_DELAY_LINES,
        NOTCH_WIDE, PEAKING_ENABLE, LOWPASS_ENABLE, LOWPASS_NOTCH})
      if (d[3:0] != 4'h0)
        `CHK("step", d[2:0], d[3] ? LOWPASS_STEP : PEAKING_STEP)
      rd(8'h09, d);
    end
    $display("test luma done");
    for (i = 0; i < 4; i++)
    begin
      d = (i == 3) ? $random(seed) : (i == 0 ? 8'h00 : (i == 1 ? 8'h80 : 8'hff));
      wr(8'h0a, d);
      tick(2);
      `CHK("brightness", d, BRIGHTNESS_OFFSET_VALUE)
      rd(8'h0a, d);
    end
    // unmapped place is acked but keeps nothing; a foreign address gets no ack
    wr(8'h0b, 8'h5a);
    rd(8'h0b, 8'h00);
    rd(8'h0a, d);
    start;
    bytex({DEV ^ 7'h01, 1'b0}, 1'b1, q, a);
    `CHK("foreign ack", 1'b1, a)
    stop;
    $display("test bus done");
    for (i = 0; i < 4; i++)
    begin
      wr(8'h08, {2'h0, i[1], 5'h18});
      SOURCE_INTERLACED <= i[0];
      tick(2);
      a = ODD_EVEN;
      // one-cycle field pulse; a longer one would toggle parity once per cycle
      FIELD_START <= 1'b1;
      tick(1);
      FIELD_START <= 1'b0;
      tick(3);
      `CHK("parity", a ^ (i[0] | i[1]), ODD_EVEN)
    end
    $display("test parity done");
    finish_test;
  end
endmodule
`default_nettype wire
